/* File: design/ora_operand_decoder.sv */
// Operand register addressing: register file, operand checks, status word
//
// Overview of operation
// - Byte codes 0..7 select X, A, C, B, E, D, L, H.
// - Pair codes 0..3 select AX, BC, DE, HL.
// - Short direct range FE20H..FF1FH; 16-bit form needs even address.
// - Absolute addresses span 0000H..FFFFH; even for 16-bit data moves.
// - Call table operand is an even address in 0040H..007FH.
// - Three-bit field selects one bit of the addressed byte.
// - Branch displacement is signed 8-bit, sign-extended for the PC add.
// - A is byte accumulator, AX word accumulator; A default destination.
// - Each pair's high and low bytes read and written separately.
// - Status word holds carry, aux carry, zero and irq enable flags.
// - Each of Z, AC, CY: keep, clear, set, from result, or restore.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module ora_operand_decoder
  import ora_pkg::*;
(
  input wire logic ref_clk_in, // Core clock
  input wire logic nrst_in, // Async reset, active low
  input wire logic [2:0] reg_operand_in, // Byte register operand code
  input wire logic [1:0] pair_operand_in, // Pair operand code
  input wire ora_wr_t wr_in, // Register file write
  input wire logic dest_default_in, // Byte write goes to accumulator
  input wire ora_flag_upd_t flag_in, // Flag update request
  input wire logic [15:0] short_address_in, // Short direct address
  input wire logic short_word_in, // Short direct is 16-bit form
  input wire logic [15:0] absolute_address_in, // Absolute address
  input wire logic absolute_word_in, // Absolute is 16-bit transfer
  input wire logic [15:0] call_table_address_in, // Table call address
  input wire logic [2:0] bit_select_in, // Bit position field
  input wire logic [7:0] bit_byte_in, // Byte holding the bit
  input wire logic [7:0] branch_displacement_in, // Signed displacement
  input wire logic [15:0] pc_in, // Program counter
  output logic [7:0] reg_data_out, // Selected byte register
  output logic [15:0] pair_data_out, // Selected pair
  output logic [7:0] pair_high_out, // High byte of selected pair
  output logic [7:0] pair_low_out, // Low byte of selected pair
  output logic [7:0] accum_out, // Byte accumulator
  output logic [15:0] accum_word_out, // Word accumulator
  output logic [7:0] status_word_out, // Status word
  output logic carry_flag_out, // Carry flag
  output logic aux_carry_flag_out, // Aux carry flag
  output logic zero_flag_out, // Zero flag
  output logic irq_enable_flag_out, // Interrupt enable flag
  output logic short_ok_out, // Short direct address legal
  output logic absolute_ok_out, // Absolute address legal
  output logic call_table_ok_out, // Table call address legal
  output logic bit_value_out, // Selected bit
  output logic [7:0] bit_mask_out, // One-hot mask of selected bit
  output logic [15:0] branch_offset_out, // Sign-extended displacement
  output logic [15:0] branch_target_out // PC plus displacement
);

  // ****************************************
  // State
  // ****************************************
  ora_state_t state;
  ora_state_t next_state;

  // Pair code to register indices
  function automatic logic [2:0] pair_hi_idx(input logic [1:0] p);
    pair_hi_idx = {p, 1'b1};
  endfunction

  function automatic logic [2:0] pair_lo_idx(input logic [1:0] p);
    pair_lo_idx = {p, 1'b0};
  endfunction

  function automatic logic apply_flag(input ora_flag_op_t op, input logic cur,
                                      input logic res, input logic sav);
    case (op)
      ORA_FLAG_CLEAR: apply_flag = 1'b0;
      ORA_FLAG_SET: apply_flag = 1'b1;
      ORA_FLAG_RESULT: apply_flag = res;
      ORA_FLAG_RESTORE: apply_flag = sav;
      default: apply_flag = cur;
    endcase
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [2:0] dst;
    dst = dest_default_in ? ORA_REG_A : wr_in.reg_sel;
    next_state = state;
    case (wr_in.kind)
      ORA_WR_BYTE: begin
        next_state.regs[dst] = wr_in.data[7:0];
      end
      ORA_WR_PAIR: begin
        next_state.regs[pair_hi_idx(wr_in.pair_sel)] = wr_in.data[15:8];
        next_state.regs[pair_lo_idx(wr_in.pair_sel)] = wr_in.data[7:0];
      end
      default: begin
      end
    endcase
    if (flag_in.sw_load) begin
      next_state.status_word = flag_in.sw_data;
    end else begin
      next_state.status_word[ORA_SW_Z] = apply_flag(flag_in.z_op,
        state.status_word[ORA_SW_Z], flag_in.z_res, flag_in.saved[ORA_SW_Z]);
      next_state.status_word[ORA_SW_AC] = apply_flag(flag_in.ac_op,
        state.status_word[ORA_SW_AC], flag_in.ac_res, flag_in.saved[ORA_SW_AC]);
      next_state.status_word[ORA_SW_CY] = apply_flag(flag_in.cy_op,
        state.status_word[ORA_SW_CY], flag_in.cy_res, flag_in.saved[ORA_SW_CY]);
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state.regs <= {ORA_NUM_REGS{ORA_REG_RESET}};
      state.status_word <= ORA_SW_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always_comb begin
    reg_data_out = state.regs[reg_operand_in];
    pair_high_out = state.regs[pair_hi_idx(pair_operand_in)];
    pair_low_out = state.regs[pair_lo_idx(pair_operand_in)];
    pair_data_out = {pair_high_out, pair_low_out};
    accum_out = state.regs[ORA_REG_A];
    accum_word_out = {state.regs[ORA_REG_A], state.regs[ORA_REG_X]};
  end

  // ****************************************
  // Status word
  // ****************************************
  always_comb begin
    status_word_out = state.status_word;
    carry_flag_out = state.status_word[ORA_SW_CY];
    aux_carry_flag_out = state.status_word[ORA_SW_AC];
    zero_flag_out = state.status_word[ORA_SW_Z];
    irq_enable_flag_out = state.status_word[ORA_SW_IE];
  end

  // ****************************************
  // Operand checks and arithmetic
  // ****************************************
  always_comb begin
    short_ok_out = (short_address_in >= ORA_SHORT_LO) &&
                   (short_address_in <= ORA_SHORT_HI) &&
                   !(short_word_in && short_address_in[0]);
    absolute_ok_out = (absolute_address_in >= ORA_ABS_LO) &&
                      (absolute_address_in <= ORA_ABS_HI) &&
                      !(absolute_word_in && absolute_address_in[0]);
    call_table_ok_out = (call_table_address_in >= ORA_TABLE_LO) &&
                        (call_table_address_in <= ORA_TABLE_HI) &&
                        !call_table_address_in[0];
    bit_mask_out = 8'h01 << bit_select_in;
    bit_value_out = bit_byte_in[bit_select_in];
    branch_offset_out = {{8{branch_displacement_in[7]}}, branch_displacement_in};
    branch_target_out = pc_in + branch_offset_out;
  end

endmodule

`default_nettype wire

/* File: inc/ora_pkg.sv */
// Package for the operand register addressing block
package ora_pkg;

  // ****************************************
  // Register file layout
  // ****************************************
  localparam int unsigned ORA_NUM_REGS = 8;
  localparam logic [2:0] ORA_REG_X = 3'h0;
  localparam logic [2:0] ORA_REG_A = 3'h1;
  localparam logic [2:0] ORA_REG_C = 3'h2;
  localparam logic [2:0] ORA_REG_B = 3'h3;
  localparam logic [2:0] ORA_REG_E = 3'h4;
  localparam logic [2:0] ORA_REG_D = 3'h5;
  localparam logic [2:0] ORA_REG_L = 3'h6;
  localparam logic [2:0] ORA_REG_H = 3'h7;
  localparam logic [1:0] ORA_PAIR_AX = 2'h0;
  localparam logic [1:0] ORA_PAIR_BC = 2'h1;
  localparam logic [1:0] ORA_PAIR_DE = 2'h2;
  localparam logic [1:0] ORA_PAIR_HL = 2'h3;
  localparam logic [7:0] ORA_REG_RESET = 8'h00;

  // ****************************************
  // Address windows
  // ****************************************
  localparam logic [15:0] ORA_SHORT_LO = 16'hFE20;
  localparam logic [15:0] ORA_SHORT_HI = 16'hFF1F;
  localparam logic [15:0] ORA_ABS_LO = 16'h0000;
  localparam logic [15:0] ORA_ABS_HI = 16'hFFFF;
  localparam logic [15:0] ORA_TABLE_LO = 16'h0040;
  localparam logic [15:0] ORA_TABLE_HI = 16'h007F;

  // ****************************************
  // Status word bit positions
  // ****************************************
  localparam int unsigned ORA_SW_CY = 0;
  localparam int unsigned ORA_SW_AC = 4;
  localparam int unsigned ORA_SW_Z = 6;
  localparam int unsigned ORA_SW_IE = 7;
  localparam logic [7:0] ORA_SW_RESET = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ORA_FLAG_KEEP,
    ORA_FLAG_CLEAR,
    ORA_FLAG_SET,
    ORA_FLAG_RESULT,
    ORA_FLAG_RESTORE
  } ora_flag_op_t;

  typedef enum logic [1:0] {
    ORA_WR_NONE,
    ORA_WR_BYTE,
    ORA_WR_PAIR
  } ora_wr_kind_t;

  typedef struct packed {
    ora_wr_kind_t kind;
    logic [2:0] reg_sel;
    logic [1:0] pair_sel;
    logic [15:0] data;
  } ora_wr_t;

  typedef struct packed {
    ora_flag_op_t z_op;
    ora_flag_op_t ac_op;
    ora_flag_op_t cy_op;
    logic z_res;
    logic ac_res;
    logic cy_res;
    logic [7:0] saved;
    logic sw_load;
    logic [7:0] sw_data;
  } ora_flag_upd_t;

  typedef struct packed {
    logic [ORA_NUM_REGS-1:0][7:0] regs;
    logic [7:0] status_word;
  } ora_state_t;

endpackage

/* File: tb/operand_register_addressing_tb.sv */
// Self-checking bench for the operand register addressing block
`timescale 1ns/1ps
`default_nettype none
module operand_register_addressing_tb import ora_pkg::*; ;
  logic ref_clk_in, nrst_in, dest_default_in, short_word_in, absolute_word_in;
  logic [2:0] reg_operand_in, bit_select_in;
  logic [1:0] pair_operand_in;
  ora_wr_t wr_in;
  ora_flag_upd_t flag_in;
  logic [15:0] short_address_in, absolute_address_in, call_table_address_in, pc_in;
  logic [7:0] bit_byte_in, branch_displacement_in, reg_data_out, pair_high_out, pair_low_out;
  logic [7:0] accum_out, status_word_out, bit_mask_out;
  logic [15:0] pair_data_out, accum_word_out, branch_offset_out, branch_target_out;
  logic carry_flag_out, aux_carry_flag_out, zero_flag_out, irq_enable_flag_out;
  logic short_ok_out, absolute_ok_out, call_table_ok_out, bit_value_out;
  int mismatches, checked, cyc;
  logic [15:0] ads [14] = '{16'h0000, 16'h003F, 16'h0040, 16'h0041, 16'h007E, 16'h007F,
    16'h0080, 16'hFE1F, 16'hFE20, 16'hFE21, 16'hFF1E, 16'hFF1F, 16'hFF20, 16'hFFFF};
  ora_flag_op_t ops [5] = '{ORA_FLAG_SET, ORA_FLAG_KEEP, ORA_FLAG_CLEAR, ORA_FLAG_RESULT,
    ORA_FLAG_RESTORE};
  logic [7:0] sws [5] = '{8'h51, 8'h51, 8'h00, 8'h51, 8'h50};
  ora_operand_decoder u_dut (.*);
  ora_fetch_model u_fetch (.ref_clk_in, .nrst_in, .pc_out(pc_in));
  initial begin
    ref_clk_in = 0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input ora_wr_kind_t k, input logic [2:0] r, input logic [15:0] d);
    @(posedge ref_clk_in) wr_in <= '{k, r, r[1:0], d};
    @(posedge ref_clk_in) wr_in.kind <= ORA_WR_NONE;
  endtask
  task automatic sel(input logic [2:0] r);
    @(posedge ref_clk_in) reg_operand_in <= r;
    pair_operand_in <= r[2:1];
    @(negedge ref_clk_in);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    logic [7:0] lo, dp;
    {nrst_in, dest_default_in, reg_operand_in, pair_operand_in, short_word_in} = '0;
    {wr_in, flag_in, absolute_word_in, bit_select_in, bit_byte_in} = '0;
    {short_address_in, absolute_address_in, call_table_address_in, branch_displacement_in} = '0;
    repeat (20) @(posedge ref_clk_in);
    nrst_in <= 1;
    @(negedge ref_clk_in) chk("status", 16'h0000, 16'(status_word_out));
    for (int i = 0; i < 8; i++) wr(ORA_WR_BYTE, i[2:0], 16'(8'hA0 + i));
    for (int i = 0; i < 8; i++) begin
      sel(i[2:0]);
      lo = 8'hA0 + 8'(i & 6);
      chk("reg", 16'(8'hA0 + i), 16'(reg_data_out));
      chk("pair", {lo + 8'h01, lo}, pair_data_out);
      chk("halves", {lo + 8'h01, lo}, {pair_high_out, pair_low_out});
    end
    chk("acc", 16'hA1A1, {accum_out, accum_word_out[15:8]});
    wr(ORA_WR_PAIR, 3'd0, 16'hBEEF);
    wr(ORA_WR_PAIR, 3'd3, 16'h1234);
    sel(3'd7);
    chk("hl", 16'h1234, {reg_data_out, pair_low_out});
    chk("ax", 16'hBEEF, accum_word_out);
    dest_default_in <= 1;
    wr(ORA_WR_BYTE, 3'd5, 16'h005A);
    dest_default_in <= 0;
    sel(3'd5);
    chk("dest", 16'hA55A, {reg_data_out, accum_out});
    $display("test registers done");
    foreach (ads[i]) for (int w = 0; w < 2; w++) begin
      @(posedge ref_clk_in) {short_address_in, absolute_address_in} <= {ads[i], ads[i]};
      {call_table_address_in, short_word_in, absolute_word_in} <= {ads[i], w[0], w[0]};
      {bit_select_in, bit_byte_in, branch_displacement_in} <= {i[2:0], ads[i][15:8], ads[i][7:0]};
      @(negedge ref_clk_in) dp = ads[i][7:0];
      chk("short", 16'(ads[i] >= 16'hFE20 && ads[i] <= 16'hFF1F && !(w && dp[0])),
        16'(short_ok_out));
      chk("abs", 16'(!(w && dp[0])), 16'(absolute_ok_out));
      chk("table", 16'(ads[i] >= 16'h0040 && ads[i] <= 16'h007F && !dp[0]),
        16'(call_table_ok_out));
      chk("bit", {7'h00, ads[i][8 + i % 8], 8'h01 << i % 8},
        {7'h00, bit_value_out, bit_mask_out});
      chk("branch", pc_in + {{8{dp[7]}}, dp}, branch_target_out);
    end
    $display("test operands done");
    {flag_in.z_res, flag_in.ac_res, flag_in.cy_res, flag_in.saved} <= {3'h7, 8'hFE};
    foreach (ops[k]) begin
      @(posedge ref_clk_in) {flag_in.z_op, flag_in.ac_op, flag_in.cy_op} <= {3{ops[k]}};
      @(negedge ref_clk_in);
      @(negedge ref_clk_in) chk("flags", 16'(sws[k]), 16'(status_word_out));
    end
    @(posedge ref_clk_in) {flag_in.sw_load, flag_in.sw_data} <= {1'b1, 8'hD1};
    @(posedge ref_clk_in) flag_in.sw_load <= 0;
    @(negedge ref_clk_in) chk("load", 16'h00D1, {8'h00, irq_enable_flag_out, zero_flag_out,
      status_word_out[5], aux_carry_flag_out, status_word_out[3:1], carry_flag_out});
    $display("test flags done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: tb/ora_fetch_model.sv */
// Fetch pipeline stand-in that advances the program counter
`timescale 1ns/1ps
`default_nettype none
module ora_fetch_model (
  input wire logic ref_clk_in, // Core clock
  input wire logic nrst_in, // Async reset, active low
  output logic [15:0] pc_out // Program counter
);
  // Starts near the top so branch targets wrap
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) pc_out <= 16'hFFF0;
    else pc_out <= pc_out + 16'h0003;
  end
endmodule
`default_nettype wire

/* File: tb/ora_props.sv */
// Checker for the operand register addressing block
`timescale 1ns/1ps
`default_nettype none
module ora_props
  import ora_pkg::*;
(
  input wire logic ref_clk_in, // Clock
  input wire logic nrst_in, // Reset
  input wire ora_wr_t wr_in, // Write
  input wire logic dest_default_in, // To A
  input wire ora_flag_upd_t flag_in, // Flags
  input wire logic [15:0] short_address_in, // Short
  input wire logic short_word_in, // Word form
  input wire logic [15:0] call_table_address_in, // Table
  input wire logic [2:0] bit_select_in, // Bit
  input wire logic [7:0] branch_displacement_in, // Disp
  input wire logic [15:0] pc_in, // PC
  input wire logic [7:0] bit_mask_out, // Mask
  input wire logic [15:0] branch_offset_out, // Offset
  input wire logic [15:0] branch_target_out, // Target
  input wire logic [7:0] accum_out, // A
  input wire logic [15:0] accum_word_out, // AX
  input wire logic carry_flag_out, // Carry
  input wire logic [7:0] status_word_out, // Status
  input wire logic short_ok_out, // Short legal
  input wire logic call_table_ok_out // Table legal
);
  logic [7:0] wr_lo;
  assign wr_lo = wr_in.data[7:0];
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_acc_pair_wr;
    wr_in.kind == ORA_WR_PAIR && wr_in.pair_sel == ORA_PAIR_AX;
  endsequence
  a_acc_pair_write: assert property (s_acc_pair_wr |=> accum_word_out == $past(wr_in.data))
    else $error("word accumulator missed pair write");
  a_byte_to_acc: assert property ((wr_in.kind == ORA_WR_BYTE && dest_default_in)
    |=> accum_out == $past(wr_lo)) else $error("default byte write missed A");
  a_carry_forced: assert property ((!flag_in.sw_load && flag_in.cy_op inside
    {ORA_FLAG_SET, ORA_FLAG_CLEAR}) |=> carry_flag_out == ($past(flag_in.cy_op) == ORA_FLAG_SET))
    else $error("carry not forced");
  a_status_load: assert property (flag_in.sw_load |=> status_word_out == $past(flag_in.sw_data))
    else $error("status word load lost");
  a_short_window: assert property (short_ok_out == (short_address_in >= ORA_SHORT_LO &&
    short_address_in <= ORA_SHORT_HI && !(short_word_in && short_address_in[0])))
    else $error("short check wrong");
  a_table_window: assert property (call_table_ok_out == (call_table_address_in >= ORA_TABLE_LO
    && call_table_address_in <= ORA_TABLE_HI && !call_table_address_in[0]))
    else $error("table check wrong");
  a_bit_mask: assert property (bit_mask_out == 8'h01 << bit_select_in)
    else $error("bit mask wrong");
  a_branch_sext: assert property (branch_offset_out == {{8{branch_displacement_in[7]}},
    branch_displacement_in} && branch_target_out == pc_in + branch_offset_out)
    else $error("branch offset wrong");
endmodule
bind ora_operand_decoder ora_props u_props (.ref_clk_in, .nrst_in, .wr_in, .dest_default_in,
  .flag_in, .short_address_in, .short_word_in, .call_table_address_in, .bit_select_in,
  .branch_displacement_in, .pc_in, .bit_mask_out, .branch_offset_out, .branch_target_out,
  .accum_out, .accum_word_out, .carry_flag_out, .status_word_out, .short_ok_out,
  .call_table_ok_out);
`default_nettype wire
